/* File: src/mdsf_pkg.sv */
package mdsf_pkg;
    localparam logic [7:0] MOTOR1_STATUS_OFFSET = 8'h6F;
    localparam logic [7:0] MOTOR2_STATUS_OFFSET = 8'h7F;
    localparam int         STANDSTILL_BIT       = 31;
    localparam int         OPEN_LOAD_B_BIT      = 30;
    localparam int         OPEN_LOAD_A_BIT      = 29;
    localparam int         SHORT_B_BIT          = 28;
    localparam int         SHORT_A_BIT          = 27;
    localparam int         PREWARN_BIT          = 26;
    localparam int         THERMAL_BIT          = 25;
    localparam int         STALL_BIT            = 24;
    localparam int         CS_MSB               = 20;
    localparam int         CS_LSB               = 16;
    localparam int         FULLSTEP_BIT         = 15;
    localparam int         LOAD_W               = 10;
    localparam int         CS_W                 = 5;
    localparam logic [3:0] OFF_TIME_OFF         = 4'h0;
    localparam logic [LOAD_W-1:0] LOAD_STALL    = 10'h000;
    localparam logic [31:0] READ_RESET          = 32'h0000_0000;
endpackage

/* File: src/mdsf_axis.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsf_axis (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // axis inputs, already synchronised
    input  wire logic                          moving,
    input  wire logic                          open_a,
    input  wire logic                          open_b,
    input  wire logic                          short_a,
    input  wire logic                          short_b,
    input  wire logic                          prewarn,
    input  wire logic                          thermal,
    input  wire logic                          load_mode,
    input  wire logic                          load_mode_stall,
    input  wire logic [mdsf_pkg::LOAD_W-1:0]   load_measure_result,
    input  wire logic [mdsf_pkg::CS_W-1:0]     cs_actual,
    input  wire logic                          fullstep,
    input  wire logic [3:0]                    chopper_off_time,
    input  wire logic                          driver_enable_n,
    // status
    output logic [31:0]                        driver_status_word,
    output logic                               power_enable
);
    logic short_a_hold;
    logic short_b_hold;
    logic release_short;

    // software clears a latched short only by switching the driver off
    assign release_short = (chopper_off_time == mdsf_pkg::OFF_TIME_OFF) || driver_enable_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            short_a_hold <= 1'b0;
            short_b_hold <= 1'b0;
        end else begin
            // new detection while releasing still latches
            short_a_hold <= short_a || (short_a_hold && !release_short); // R4 R5
            short_b_hold <= short_b || (short_b_hold && !release_short); // R4 R5
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_enable <= 1'b0;
        end else begin
            power_enable <= !release_short && !short_a_hold && !short_b_hold
                            && !short_a && !short_b && !thermal; // R4 R7
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driver_status_word <= mdsf_pkg::READ_RESET;
        end else begin
            driver_status_word <= '0;
            driver_status_word[mdsf_pkg::STANDSTILL_BIT] <= !moving; // R1
            driver_status_word[mdsf_pkg::OPEN_LOAD_B_BIT] <= open_b; // R2
            driver_status_word[mdsf_pkg::OPEN_LOAD_A_BIT] <= open_a; // R2
            driver_status_word[mdsf_pkg::SHORT_B_BIT] <= short_b_hold || short_b; // R4
            driver_status_word[mdsf_pkg::SHORT_A_BIT] <= short_a_hold || short_a; // R4
            driver_status_word[mdsf_pkg::PREWARN_BIT] <= prewarn; // R6
            driver_status_word[mdsf_pkg::THERMAL_BIT] <= thermal; // R7
            driver_status_word[mdsf_pkg::STALL_BIT] <= load_mode ? load_mode_stall
                : (load_measure_result == mdsf_pkg::LOAD_STALL); // R8
            driver_status_word[mdsf_pkg::CS_MSB:mdsf_pkg::CS_LSB] <= cs_actual; // R9
            driver_status_word[mdsf_pkg::FULLSTEP_BIT] <= fullstep; // R10
        end
    end
endmodule
`default_nettype wire

/* File: src/mdsf_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: standstill bit 31 set whenever motor is not moving, in any mode.
// R2: open-load bits 30 (B) and 29 (A) are informational; driver ignores them.
// R3: software should check open-load only in slow motion or after a move.
// R4: ground short sets bit 28 (B) or 27 (A) and disables the power stage.
// R5: short flags hold until off-time is zero or enable input deasserted.
// R6: pre-warning bit 26 is one chip-wide flag shared by both drivers.
// R7: overtemperature bit 25 is chip-wide, disabling both drivers until pre-warning clears.
// R8: stall bit 24 when load result is zero, or load-mode stall in that mode.
// R9: bits 20..16 report applied adaptive coil current scale.
// R10: bit 15 shows the driver switched to fullstep operation.
// R11: status read-only; reads do not clear; writes ignored.
module mdsf_top (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    output logic [31:0]                        reg_rdata,
    // chip-wide thermal sensing, asynchronous
    input  wire logic                          temp_prewarn,
    input  wire logic                          temp_limit,
    // motor one analog detector and core inputs
    input  wire logic                          m1_moving,
    input  wire logic                          m1_open_a,
    input  wire logic                          m1_open_b,
    input  wire logic                          m1_short_a,
    input  wire logic                          m1_short_b,
    input  wire logic                          m1_load_mode,
    input  wire logic                          m1_load_mode_stall,
    input  wire logic [mdsf_pkg::LOAD_W-1:0]   m1_load_measure_result,
    input  wire logic [mdsf_pkg::CS_W-1:0]     m1_cs_actual,
    input  wire logic                          m1_fullstep,
    input  wire logic [3:0]                    m1_chopper_off_time,
    // motor two
    input  wire logic                          m2_moving,
    input  wire logic                          m2_open_a,
    input  wire logic                          m2_open_b,
    input  wire logic                          m2_short_a,
    input  wire logic                          m2_short_b,
    input  wire logic                          m2_load_mode,
    input  wire logic                          m2_load_mode_stall,
    input  wire logic [mdsf_pkg::LOAD_W-1:0]   m2_load_measure_result,
    input  wire logic [mdsf_pkg::CS_W-1:0]     m2_cs_actual,
    input  wire logic                          m2_fullstep,
    input  wire logic [3:0]                    m2_chopper_off_time,
    // enable pin, shared, active low
    input  wire logic                          driver_enable_n,
    // power stage enables
    output logic                               m1_power_enable,
    output logic                               m2_power_enable
);
    localparam int NSYNC = 10;

    logic [1:0]       rst_sync;
    logic             rst_n;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic             thermal_hold;
    logic [31:0]      status_m1;
    logic [31:0]      status_m2;
    logic             pe1;
    logic             pe2;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins from the analog side are asynchronous to sys_clk
    assign async_in = {temp_prewarn, temp_limit, driver_enable_n,
                       m1_open_a, m1_open_b, m1_short_a, m1_short_b,
                       m2_open_a, m2_open_b, m2_short_a};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    logic s_prewarn;
    logic s_limit;
    logic s_enable_n;
    logic m2_short_b_a;
    logic m2_short_b_s;
    assign s_prewarn  = sync_b[9];
    assign s_limit    = sync_b[8];
    assign s_enable_n = sync_b[7];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            m2_short_b_a <= 1'b0;
            m2_short_b_s <= 1'b0;
        end else begin
            m2_short_b_a <= m2_short_b;
            m2_short_b_s <= m2_short_b_a;
        end
    end

    // shutdown latches at the limit and outlasts it until pre-warning drops too
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_hold <= 1'b0;
        end else begin
            thermal_hold <= s_limit || (thermal_hold && s_prewarn); // R7
        end
    end

    mdsf_axis u_axis1 (
        .clk                 (sys_clk),
        .rst_n               (rst_n),
        .moving              (m1_moving),
        .open_a              (sync_b[6]),
        .open_b              (sync_b[5]),
        .short_a             (sync_b[4]),
        .short_b             (sync_b[3]),
        .prewarn             (s_prewarn),
        .thermal             (thermal_hold),
        .load_mode           (m1_load_mode),
        .load_mode_stall     (m1_load_mode_stall),
        .load_measure_result (m1_load_measure_result),
        .cs_actual           (m1_cs_actual),
        .fullstep            (m1_fullstep),
        .chopper_off_time    (m1_chopper_off_time),
        .driver_enable_n     (s_enable_n),
        .driver_status_word  (status_m1),
        .power_enable        (pe1)
    );

    mdsf_axis u_axis2 (
        .clk                 (sys_clk),
        .rst_n               (rst_n),
        .moving              (m2_moving),
        .open_a              (sync_b[2]),
        .open_b              (sync_b[1]),
        .short_a             (sync_b[0]),
        .short_b             (m2_short_b_s),
        .prewarn             (s_prewarn),
        .thermal             (thermal_hold),
        .load_mode           (m2_load_mode),
        .load_mode_stall     (m2_load_mode_stall),
        .load_measure_result (m2_load_measure_result),
        .cs_actual           (m2_cs_actual),
        .fullstep            (m2_fullstep),
        .chopper_off_time    (m2_chopper_off_time),
        .driver_enable_n     (s_enable_n),
        .driver_status_word  (status_m2),
        .power_enable        (pe2)
    );

    assign m1_power_enable = pe1;
    assign m2_power_enable = pe2;

    // reads have no side effect; writes are not decoded at all
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= mdsf_pkg::READ_RESET;
        end else if (reg_read) begin
            unique case (reg_addr)
                mdsf_pkg::MOTOR1_STATUS_OFFSET: reg_rdata <= status_m1; // R11
                mdsf_pkg::MOTOR2_STATUS_OFFSET: reg_rdata <= status_m2; // R11
                default:                        reg_rdata <= mdsf_pkg::READ_RESET;
            endcase
        end else begin
            reg_rdata <= mdsf_pkg::READ_RESET;
        end
    end

    logic unused_ok;
    assign unused_ok = reg_write ^ (^reg_wdata);
endmodule
`default_nettype wire

/* File: tb/mdsf_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsf_top_properties (
    // clock, reset and register port
    input wire logic                        sys_clk, resetn, reg_read,
    input wire logic [7:0]                  reg_addr,
    input wire logic [31:0]                 reg_rdata,
    // sensed levels
    input wire logic                        temp_prewarn, temp_limit, driver_enable_n,
    input wire logic                        m1_moving, m1_short_a,
    input wire logic [3:0]                  m1_chopper_off_time,
    input wire logic                        m2_load_mode, m2_load_mode_stall, m2_fullstep,
    input wire logic [mdsf_pkg::LOAD_W-1:0] m2_load_measure_result,
    input wire logic [mdsf_pkg::CS_W-1:0]   m2_cs_actual,
    // power stage
    input wire logic                        m1_power_enable, m2_power_enable
);
    wire logic rd1 = reg_read && reg_addr == mdsf_pkg::MOTOR1_STATUS_OFFSET;
    wire logic rd2 = reg_read && reg_addr == mdsf_pkg::MOTOR2_STATUS_OFFSET;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // stable input lets the check hold whether the word lags one cycle or none
    property p_standstill; rd1 && $stable(m1_moving) |=> reg_rdata[31] == !$past(m1_moving, 2);
    endproperty
    a_standstill: assert property (p_standstill) else $error("standstill bit wrong");
    property p_short_off; m1_short_a |-> ##[1:6] !m1_power_enable;
    endproperty
    a_short_off: assert property (p_short_off) else $error("short left stage on");
    property p_short_hold;
        $fell(m1_short_a) && m1_chopper_off_time != 4'h0 && !driver_enable_n |-> !m1_power_enable [*4];
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("short fault not held");
    property p_hot_off; temp_limit |-> ##[1:6] (!m1_power_enable && !m2_power_enable);
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("overheat left stage on");
    property p_hot_hold; temp_prewarn && $fell(temp_limit) |-> (!m1_power_enable && !m2_power_enable) [*4];
    endproperty
    a_hot_hold: assert property (p_hot_hold) else $error("shutdown ended early");
    property p_stall;
        rd2 && $stable(m2_load_mode) && $stable(m2_load_mode_stall) && $stable(m2_load_measure_result)
        |=> reg_rdata[24] == ($past(m2_load_mode, 2) ? $past(m2_load_mode_stall, 2)
                              : $past(m2_load_measure_result, 2) == mdsf_pkg::LOAD_STALL);
    endproperty
    a_stall: assert property (p_stall) else $error("stall bit wrong");
    property p_scale; rd2 && $stable(m2_cs_actual) && $stable(m2_fullstep)
        |=> reg_rdata[20:16] == $past(m2_cs_actual, 2) && reg_rdata[15] == $past(m2_fullstep, 2);
    endproperty
    a_scale: assert property (p_scale) else $error("scale or fullstep wrong");
    property p_idle_zero; !(rd1 || rd2) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data without valid read");
    c_short: cover property (m1_short_a && !m1_power_enable);
    c_hot: cover property (temp_prewarn && $fell(temp_limit));
    c_stall: cover property (rd2 && m2_load_mode);
endmodule
`default_nettype wire

/* File: tb/mdsf_coil_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsf_coil_model (
    // bridge drive from the driver
    input  wire logic power_enable,
    // motion and fault scenario
    input  wire logic run, cut_a, cut_b, gnd_a, gnd_b,
    // detector levels
    output logic      moving, open_a, open_b, short_a, short_b
);
    // a dead bridge senses nothing, so live fault levels vanish once the stage is off
    assign moving  = run && power_enable;
    assign open_a  = cut_a && power_enable;
    assign open_b  = cut_b && power_enable;
    assign short_a = gnd_a && power_enable;
    assign short_b = gnd_b && power_enable;
endmodule
`default_nettype wire

/* File: tb/tb_motor_driver_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_motor_driver_status_flags;
    logic        sys_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, pend = 1'b0;
    logic        prewarn = 1'b0, limit = 1'b0, enable_n = 1'b0, th = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, q[$];
    logic        run[2], cut_a[2], cut_b[2], gnd_a[2], gnd_b[2], lm[2], lms[2], fs[2];
    logic        xsa[2], xsb[2], pon[2];
    logic [9:0]  lr[2];
    logic [4:0]  cs[2];
    logic [3:0]  coff[2];
    wire logic   mv[2], oa[2], ob[2], sa[2], sb[2], pe[2];
    int          n_mismatch = 0, samples_checked = 0;
    always #2 sys_clk = ~sys_clk;
    mdsf_top dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .temp_prewarn(prewarn), .temp_limit(limit), .driver_enable_n(enable_n),
        .m1_moving(mv[0]), .m1_open_a(oa[0]), .m1_open_b(ob[0]), .m1_short_a(sa[0]),
        .m1_short_b(sb[0]), .m1_load_mode(lm[0]), .m1_load_mode_stall(lms[0]),
        .m1_load_measure_result(lr[0]), .m1_cs_actual(cs[0]), .m1_fullstep(fs[0]),
        .m1_chopper_off_time(coff[0]), .m2_moving(mv[1]), .m2_open_a(oa[1]), .m2_open_b(ob[1]),
        .m2_short_a(sa[1]), .m2_short_b(sb[1]), .m2_load_mode(lm[1]), .m2_load_mode_stall(lms[1]),
        .m2_load_measure_result(lr[1]), .m2_cs_actual(cs[1]), .m2_fullstep(fs[1]),
        .m2_chopper_off_time(coff[1]), .m1_power_enable(pe[0]), .m2_power_enable(pe[1]));
    for (genvar i = 0; i < 2; i++) begin : g_coil
        mdsf_coil_model coil (.power_enable(pe[i]), .run(run[i]), .cut_a(cut_a[i]),
            .cut_b(cut_b[i]), .gnd_a(gnd_a[i]), .gnd_b(gnd_b[i]), .moving(mv[i]),
            .open_a(oa[i]), .open_b(ob[i]), .short_a(sa[i]), .short_b(sb[i]));
    end
    function automatic logic [31:0] exp_word(input int i);
        return {!(run[i] && pon[i]), cut_b[i] && pon[i], cut_a[i] && pon[i], xsb[i], xsa[i],
                prewarn, th, lm[i] ? lms[i] : lr[i] == mdsf_pkg::LOAD_STALL, 3'h0, cs[i], fs[i],
                15'h0000};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        reg_addr  <= a;
        q.push_back(e);
        @(posedge sys_clk);
    endtask
    task automatic idle(input int n);
        reg_read  <= 1'b0;
        reg_write <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    // back-to-back reads of both axes and one unmapped place
    task automatic rd_all;
        rd(mdsf_pkg::MOTOR1_STATUS_OFFSET, exp_word(0));
        rd(mdsf_pkg::MOTOR2_STATUS_OFFSET, exp_word(1));
        rd(8'h70, 32'h0000_0000);
        idle(2);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (pend)
            chk(reg_rdata, q.pop_front());
        pend <= reg_read;
    end
    // tests take about 250 cycles; 10000 leaves ample margin
    initial begin
        #40000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        for (int i = 0; i < 2; i++) begin
            {run[i], cut_a[i], cut_b[i], gnd_a[i], gnd_b[i], lm[i], lms[i], fs[i]} = 8'h80;
            {xsa[i], xsb[i], pon[i]} = 3'b001;
            {lr[i], cs[i], coff[i]} = {10'h155, 5'h1F, 4'h5};
        end
        void'($urandom(53));
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        idle(10);
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 2; i++) begin
                {run[i], cut_a[i], cut_b[i], lm[i], lms[i], fs[i]} <= 6'($urandom);
                lr[i] <= k[0] ? 10'h000 : 10'($urandom);
                cs[i] <= 5'($urandom);
            end
            idle(6);
            reg_write <= 1'b1;
            reg_addr  <= mdsf_pkg::MOTOR1_STATUS_OFFSET;
            reg_wdata <= $urandom;
            @(posedge sys_clk);
            rd_all;
            chk(pe[0], 1'b1);
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) gnd_a[0] <= 1'b1; else gnd_b[0] <= 1'b1;
            {xsa[0], xsb[0], pon[0]} = (k == 0) ? 3'b100 : 3'b010;
            idle(8);
            chk({pe[0], pe[1]}, 2'b01);
            gnd_a[0] <= 1'b0;
            gnd_b[0] <= 1'b0;
            idle(8);
            rd_all;
            chk(pe[0], 1'b0);
            if (k == 0) coff[0] <= mdsf_pkg::OFF_TIME_OFF; else enable_n <= 1'b1;
            idle(8);
            coff[0]  <= 4'h5;
            enable_n <= 1'b0;
            {xsa[0], xsb[0], pon[0]} = 3'b001;
            idle(8);
            rd_all;
            chk(pe[0], 1'b1);
        end
        prewarn <= 1'b1;
        idle(8);
        rd_all;
        limit <= 1'b1;
        {th, pon[0], pon[1]} = 3'b100;
        idle(8);
        chk({pe[0], pe[1]}, 2'b00);
        limit <= 1'b0;
        idle(8);
        rd_all;
        chk({pe[0], pe[1]}, 2'b00);
        prewarn <= 1'b0;
        {th, pon[0], pon[1]} = 3'b011;
        idle(8);
        rd_all;
        chk({pe[0], pe[1]}, 2'b11);
        wrap_up;
    end
endmodule
bind mdsf_top mdsf_top_properties u_props (.sys_clk(sys_clk), .resetn(resetn),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .temp_prewarn(temp_prewarn), .temp_limit(temp_limit), .driver_enable_n(driver_enable_n),
    .m1_moving(m1_moving), .m1_short_a(m1_short_a), .m1_chopper_off_time(m1_chopper_off_time),
    .m2_load_mode(m2_load_mode), .m2_load_mode_stall(m2_load_mode_stall),
    .m2_fullstep(m2_fullstep), .m2_load_measure_result(m2_load_measure_result),
    .m2_cs_actual(m2_cs_actual), .m1_power_enable(m1_power_enable),
    .m2_power_enable(m2_power_enable));
`default_nettype wire
